// ==== dv/ibd_line_src.sv ====
`timescale 1ns/100ps
// ---------------------------------------------------------------
// Receive line source, clock stands still while idle
// ---------------------------------------------------------------
module ibd_line_src (
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire logic run_in,
    input wire logic [7:0] code_in,
    input wire logic [3:0] len_in,
    output logic line_clk_out,
    output logic line_data_out
);
    logic [2:0] phase_q;
    logic [2:0] idx_q;
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            phase_q <= 3'h0;
            idx_q <= 3'h0;
            line_clk_out <= 1'b0;
            line_data_out <= 1'b0;
        end else if (run_in) begin
            phase_q <= phase_q + 3'h1;
            line_clk_out <= ~phase_q[2];
            // Data moves mid low phase, so it is steady around the rising edge
            if (phase_q == 3'h5) begin
                line_data_out <= code_in[3'h7 - idx_q];
                idx_q <= ({1'b0, idx_q} == len_in - 4'h1) ? 3'h0 : idx_q + 3'h1;
            end
        end else begin
            phase_q <= 3'h0;
            line_clk_out <= 1'b0;
            // Idle data keeps moving so a stale bit never looks valid
            line_data_out <= ~line_data_out;
        end
    end
endmodule

// ==== dv/inband_loopback_code_detector_bench.sv ====
`timescale 1ns/100ps
module inband_loopback_code_detector_bench;
    logic clock_in = 1'b0;
    logic nrst_in = 1'b0;
    logic line_mode_select_in = 1'b0;
    logic run = 1'b0;
    logic [7:0] code = 8'h00;
    logic [3:0] len = 4'h5;
    logic line_clk;
    logic line_data;
    ibd_pkg::ibd_cpu_req_t cpu_req_in = '0;
    logic [7:0] cpu_rdata_out;
    logic irq_out_n;
    logic act_st;
    logic deact_st;
    int num_errors = 0;
    int samples_checked = 0;
    // Short interval and hit count keep the run small
    ibd_detector #(.OBS_CYCLES(400), .HITS_MIN(4), .SUSTAIN_INTERVALS(2)) i_ibd_detector (
        .clock_in(clock_in), .nrst_in(nrst_in), .line_mode_select_in(line_mode_select_in),
        .line_clk_in(line_clk), .line_data_in(line_data), .cpu_req_in(cpu_req_in),
        .cpu_rdata_out(cpu_rdata_out), .irq_out_n(irq_out_n),
        .act_detect_state_out(act_st), .deact_detect_state_out(deact_st));
    ibd_line_src i_ibd_line_src (.clock_in(clock_in), .nrst_in(nrst_in), .run_in(run),
        .code_in(code), .len_in(len), .line_clk_out(line_clk), .line_data_out(line_data));
    initial begin
        forever #2 clock_in = ~clock_in;
    end
    // ---------------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_in);
        cpu_req_in <= '{sel: 1'b1, wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clock_in);
        cpu_req_in <= '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock_in);
        cpu_req_in <= '{sel: 1'b1, wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clock_in);
        cpu_req_in <= '0;
        #1;
        check("read data", cpu_rdata_out, exp);
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_reset();
        for (int a = 8'h4C; a <= 8'h50; a++) begin
            rd(8'(a), 8'h00);
        end
        check("irq", {7'h00, irq_out_n}, 8'h01);
    endtask
    task automatic t_regs();
        wr(8'h4C, 8'hFF);
        rd(8'h4C, 8'h8F);
        wr(8'h4D, 8'hFF);
        rd(8'h4D, 8'h30);
        wr(8'h4E, 8'hA5);
        rd(8'h4E, 8'hA5);
        wr(8'h4F, 8'h5A);
        rd(8'h4F, 8'h5A);
        wr(8'h4C, 8'h08);
        wr(8'h4D, 8'h20);
    endtask
    task automatic t_activate();
        wr(8'h4E, 8'h08);
        wr(8'h4F, 8'h16);
        code <= 8'h08;
        len <= 4'h5;
        run <= 1'b1;
        for (int i = 0; i < 3000 && irq_out_n !== 1'b0; i++) @(negedge clock_in);
        check("act state", {7'h00, act_st}, 8'h01);
        check("irq", {7'h00, irq_out_n}, 8'h00);
        rd(8'h4D, 8'hAA);
        rd(8'h4D, 8'hA2);
        check("irq", {7'h00, irq_out_n}, 8'h01);
    endtask
    task automatic t_deact();
        wr(8'h4D, 8'h10);
        code <= 8'h16;
        len <= 4'h7;
        for (int i = 0; i < 3000 && !(deact_st === 1'b1 && act_st === 1'b0); i++)
            @(negedge clock_in);
        check("deact state", {7'h00, deact_st}, 8'h01);
        check("irq", {7'h00, irq_out_n}, 8'h00);
        rd(8'h4D, 8'h55);
    endtask
    task automatic t_line_mode();
        run <= 1'b0;
        line_mode_select_in <= 1'b1;
        wr(8'h4E, 8'h77);
        rd(8'h4F, 8'h00);
        check("deact state", {7'h00, deact_st}, 8'h00);
        check("irq", {7'h00, irq_out_n}, 8'h01);
        line_mode_select_in <= 1'b0;
        rd(8'h4E, 8'h00);
        rd(8'h4C, 8'h00);
    endtask
    task automatic t_short();
        wr(8'h4C, 8'h04);
        wr(8'h4F, 8'h24);
        wr(8'h4D, 8'h10);
        code <= 8'h24;
        len <= 4'h3;
        run <= 1'b1;
        for (int i = 0; i < 3000 && deact_st !== 1'b1; i++) @(negedge clock_in);
        check("short code state", {7'h00, deact_st}, 8'h01);
        check("irq", {7'h00, irq_out_n}, 8'h00);
        rd(8'h4D, 8'h55);
    endtask
    initial begin
        repeat (12) @(posedge clock_in);
        nrst_in <= 1'b1;
        t_reset();
        t_regs();
        t_activate();
        t_deact();
        t_line_mode();
        t_short();
        wrap_up();
    end
    initial begin
        repeat (20000) @(posedge clock_in);
        num_errors++;
        wrap_up();
    end
endmodule

// ==== rtl/ibd_detector.sv ====
`timescale 1ns/100ps
// How it works
// - Line mode E1 holds all registers reset
// - Length fields 00..11 give 5..8 bits
// - Code MSB compares against earliest received bit
// - Presence bits per 39.8 ms interval
// - Activate state change interrupts when enabled
// - Deactivate state change interrupts when enabled
// - Event bits mark interrupting state changes
// - State bits show live detect indications
// - Reset clears codes, enables and status
module ibd_detector #(
    parameter int OBS_CYCLES = ibd_pkg::OBS_CYCLES,
    parameter int HITS_MIN = ibd_pkg::HITS_MIN,
    parameter int SUSTAIN_INTERVALS = ibd_pkg::SUSTAIN_INTERVALS
) (
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire logic line_mode_select_in,
    input wire logic line_clk_in,
    input wire logic line_data_in,
    input wire ibd_pkg::ibd_cpu_req_t cpu_req_in,
    output logic [7:0] cpu_rdata_out,
    output logic irq_out_n,
    output logic act_detect_state_out,
    output logic deact_detect_state_out
);
    ibd_pkg::ibd_state_t q;
    ibd_pkg::ibd_state_t d;
    logic bit_tick_w;
    logic obs_end_w;
    logic rd_clr_w;
    logic [7:0] hist_w;
    logic [1:0] match_w;
    logic [1:0] good_w;
    logic [1:0] chg_w;

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        logic [7:0] code;
        logic [3:0] len;
        logic pres;
        logic [3:0] half;
        code = ibd_pkg::RST_BYTE;
        len = ibd_pkg::LEN_BASE;
        pres = 1'b0;
        half = 4'h0;
        d = q;
        match_w = 2'b00;
        good_w = 2'b00;
        chg_w = 2'b00;
        // Line clock is foreign: both pins pass two flops first
        d.clk_s1 = line_clk_in;
        d.clk_s2 = q.clk_s1;
        d.clk_s3 = q.clk_s2;
        d.dat_s1 = line_data_in;
        d.dat_s2 = q.dat_s1;
        bit_tick_w = q.clk_s2 & ~q.clk_s3;
        hist_w = {q.hist[6:0], q.dat_s2};
        if (bit_tick_w) begin
            d.hist = hist_w;
        end
        obs_end_w = (q.tick == 24'(OBS_CYCLES - 1));
        d.tick = obs_end_w ? 24'h000000 : q.tick + 24'h000001;
        rd_clr_w = cpu_req_in.sel && cpu_req_in.rd
            && cpu_req_in.addr == ibd_pkg::ADDR_IRQ_ENST;
        // ---------------------------------------------------------------
        // Per-code detectors
        // ---------------------------------------------------------------
        for (int i = 0; i < 2; i++) begin
            if (i == ibd_pkg::CODE_ACT) begin
                code = q.act_code;
                len = ibd_pkg::LEN_BASE
                    + {2'b00, q.len_cfg[ibd_pkg::CFG_ACT_LO +: 2]};
            end else begin
                code = q.deact_code;
                len = ibd_pkg::LEN_BASE
                    + {2'b00, q.len_cfg[ibd_pkg::CFG_DEACT_LO +: 2]};
            end
            // Oldest bit sits at hist[7], facing the code MSB
            match_w[i] = bit_tick_w && hist_w == code;
            // A hit counts one period after the last; doubled short codes at half
            half = {1'b0, len[3:1]} - 4'h1;
            good_w[i] = match_w[i] && (q.det[i].gap == len - 4'h1
                || (!len[0] && q.det[i].gap == half));
            if (match_w[i]) begin
                d.det[i].gap = 4'h0;
            end else if (bit_tick_w && q.det[i].gap != ibd_pkg::GAP_MAX) begin
                d.det[i].gap = q.det[i].gap + 4'h1;
            end
            if (good_w[i] && q.det[i].hits != 16'hFFFF) begin
                d.det[i].hits = q.det[i].hits + 16'h0001;
            end
            if (obs_end_w) begin
                pres = q.det[i].hits >= 16'(HITS_MIN);
                d.det[i].present = pres;
                d.det[i].hits = {15'h0000, good_w[i]};
                // Hysteresis over whole intervals rides out bit errors
                if (pres == q.det[i].state) begin
                    d.det[i].run = 2'b00;
                end else if (q.det[i].run == 2'(SUSTAIN_INTERVALS - 1)) begin
                    d.det[i].run = 2'b00;
                    d.det[i].state = pres;
                    chg_w[i] = 1'b1;
                end else begin
                    d.det[i].run = q.det[i].run + 2'b01;
                end
            end
            if (rd_clr_w) begin
                d.det[i].event_hit = 1'b0;
            end
            // Set after clear: a change in the read cycle survives
            if (chg_w[i] && q.irq_en[i]) begin
                d.det[i].event_hit = 1'b1;
            end
        end
        // ---------------------------------------------------------------
        // Register port
        // ---------------------------------------------------------------
        if (cpu_req_in.sel && cpu_req_in.wr) begin
            case (cpu_req_in.addr)
                ibd_pkg::ADDR_LEN_CFG: begin
                    d.len_cfg = cpu_req_in.wdata & ibd_pkg::CFG_WR_MASK;
                end
                ibd_pkg::ADDR_IRQ_ENST: begin
                    d.irq_en[ibd_pkg::CODE_ACT] = cpu_req_in.wdata[ibd_pkg::ST_ACT_EN];
                    d.irq_en[ibd_pkg::CODE_DEACT] =
                        cpu_req_in.wdata[ibd_pkg::ST_DEACT_EN];
                end
                ibd_pkg::ADDR_ACT_CODE: begin
                    d.act_code = cpu_req_in.wdata;
                end
                ibd_pkg::ADDR_DEACT_CODE: begin
                    d.deact_code = cpu_req_in.wdata;
                end
                default: begin
                end
            endcase
        end
        // Read data is registered and holds until the next read
        if (cpu_req_in.sel && cpu_req_in.rd) begin
            case (cpu_req_in.addr)
                ibd_pkg::ADDR_LEN_CFG: begin
                    d.rdata = q.len_cfg;
                end
                ibd_pkg::ADDR_IRQ_ENST: begin
                    d.rdata = {q.det[0].present, q.det[1].present,
                        q.irq_en[0], q.irq_en[1],
                        q.det[0].event_hit, q.det[1].event_hit,
                        q.det[0].state, q.det[1].state};
                end
                ibd_pkg::ADDR_ACT_CODE: begin
                    d.rdata = q.act_code;
                end
                ibd_pkg::ADDR_DEACT_CODE: begin
                    d.rdata = q.deact_code;
                end
                default: begin
                    d.rdata = ibd_pkg::RST_BYTE;
                end
            endcase
        end
        // E1 operation keeps registers and both code detectors in reset; interval counter and bit history run on
        if (line_mode_select_in) begin
            d.len_cfg = ibd_pkg::RST_BYTE;
            d.irq_en = 2'b00;
            d.act_code = ibd_pkg::RST_BYTE;
            d.deact_code = ibd_pkg::RST_BYTE;
            d.det = '0;
        end
        d.irq_n = ~(d.det[0].event_hit | d.det[1].event_hit);
    end

    // ---------------------------------------------------------------
    // State register
    // ---------------------------------------------------------------
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            q <= '0;
            q.irq_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign cpu_rdata_out = q.rdata;
    assign irq_out_n = q.irq_n;
    assign act_detect_state_out = q.det[0].state;
    assign deact_detect_state_out = q.det[1].state;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!nrst_in);

    mode_hold_a: assert property (line_mode_select_in |=>
        q.len_cfg == 8'h00 && q.act_code == 8'h00 && q.irq_en == 2'b00
        && q.det == '0)
        else $error("detector not held reset in E1 mode");
    cfg_write_a: assert property (cpu_req_in.sel && cpu_req_in.wr
        && cpu_req_in.addr == ibd_pkg::ADDR_LEN_CFG && !line_mode_select_in
        |=> q.len_cfg == ($past(cpu_req_in.wdata) & ibd_pkg::CFG_WR_MASK))
        else $error("length register write did not land");
    code_write_a: assert property (cpu_req_in.sel && cpu_req_in.wr
        && cpu_req_in.addr == ibd_pkg::ADDR_DEACT_CODE && !line_mode_select_in
        |=> q.deact_code == $past(cpu_req_in.wdata))
        else $error("deactivate code write did not land");
    len_gap_a: assert property (good_w[0] |->
        q.det[0].gap == 4'h4 + {2'b00, q.len_cfg[1:0]}
        || (q.len_cfg[0] && q.det[0].gap == 4'h2 + {3'b000, q.len_cfg[1]}))
        else $error("activate hit spacing does not follow length");
    deact_gap_a: assert property (good_w[1] |->
        q.det[1].gap == 4'h4 + {2'b00, q.len_cfg[3:2]}
        || (q.len_cfg[2] && q.det[1].gap == 4'h2 + {3'b000, q.len_cfg[3]}))
        else $error("deactivate hit spacing does not follow length");
    first_bit_a: assert property (match_w[1] |->
        q.hist[6] == q.deact_code[7] && q.dat_s2 == q.deact_code[0])
        else $error("deactivate code bit order wrong");
    present_a: assert property (obs_end_w && !line_mode_select_in |=>
        q.det[0].present == ($past(q.det[0].hits) >= 16'(HITS_MIN)))
        else $error("presence bit disagrees with interval hits");
    deact_present_a: assert property (obs_end_w && !line_mode_select_in |=>
        q.det[1].present == ($past(q.det[1].hits) >= 16'(HITS_MIN)))
        else $error("deactivate presence bit disagrees with interval hits");
    hits_clear_a: assert property (obs_end_w && !line_mode_select_in |=>
        q.det[0].hits <= 16'h0001 && q.det[1].hits <= 16'h0001)
        else $error("hit counters not restarted at interval end");
    tick_wrap_a: assert property (obs_end_w |=> q.tick == 24'h000000)
        else $error("interval counter did not wrap");
    state_hold_a: assert property (!obs_end_w && !line_mode_select_in |=>
        $stable(q.det[0].state) && $stable(q.det[1].state))
        else $error("detect state moved inside an interval");

    // ---------------------------------------------------------------
    // Interrupt checks
    // ---------------------------------------------------------------
    act_irq_a: assert property ($changed(q.det[0].state)
        && $past(q.irq_en[0]) && !$past(line_mode_select_in)
        |-> q.det[0].event_hit ##1 1'b1)
        else $error("activate change lost its interrupt");
    act_noirq_a: assert property (!q.irq_en[0] && !q.det[0].event_hit
        |=> !q.det[0].event_hit)
        else $error("disabled activate change raised an event");
    act_pin_a: assert property ($rose(q.det[0].event_hit) |-> !irq_out_n)
        else $error("activate event did not drive the pin");
    deact_irq_a: assert property ($rose(q.det[1].event_hit) |->
        !irq_out_n && $past(q.irq_en[1]))
        else $error("deactivate event without pin or enable");
    deact_set_a: assert property ($changed(q.det[1].state)
        && $past(q.irq_en[1]) && !$past(line_mode_select_in)
        |-> q.det[1].event_hit)
        else $error("deactivate change lost its interrupt");
    deact_noirq_a: assert property (!q.irq_en[1] && !q.det[1].event_hit
        |=> !q.det[1].event_hit)
        else $error("disabled deactivate change raised an event");
    event_src_a: assert property ($rose(q.det[0].event_hit) |->
        $changed(q.det[0].state))
        else $error("activate event without a state change");
    deact_src_a: assert property ($rose(q.det[1].event_hit) |->
        $changed(q.det[1].state))
        else $error("deactivate event without a state change");
    event_hold_a: assert property (q.det[1].event_hit && !rd_clr_w
        && !line_mode_select_in |=> q.det[1].event_hit)
        else $error("deactivate event lost before a status read");
    en_write_a: assert property (cpu_req_in.sel && cpu_req_in.wr
        && cpu_req_in.addr == ibd_pkg::ADDR_IRQ_ENST && !line_mode_select_in
        |=> q.irq_en[0] == $past(cpu_req_in.wdata[ibd_pkg::ST_ACT_EN])
        && q.irq_en[1] == $past(cpu_req_in.wdata[ibd_pkg::ST_DEACT_EN]))
        else $error("interrupt enable write did not land");

    // ---------------------------------------------------------------
    // Status read and detect state checks
    // ---------------------------------------------------------------
    state_read_a: assert property (rd_clr_w ##1 !line_mode_select_in |->
        cpu_rdata_out[1:0] == $past({q.det[0].state, q.det[1].state}, 1))
        else $error("state bits read back wrong");
    present_read_a: assert property (rd_clr_w ##1 !line_mode_select_in |->
        cpu_rdata_out[7:6] == $past({q.det[0].present, q.det[1].present}, 1))
        else $error("presence bits read back wrong");
    read_clr_a: assert property (rd_clr_w && chg_w == 2'b00
        && !line_mode_select_in |=> irq_out_n && q.det[0].event_hit == 1'b0)
        else $error("status read did not clear events");
    sustain_a: assert property ($rose(q.det[0].state) |->
        q.det[0].present && $past(obs_end_w))
        else $error("activate detect rose without presence");
    deact_sustain_a: assert property ($rose(q.det[1].state) |->
        q.det[1].present && $past(obs_end_w))
        else $error("deactivate detect rose without presence");
    act_fall_a: assert property ($fell(q.det[0].state) |->
        $past(line_mode_select_in) || (!q.det[0].present && $past(obs_end_w)))
        else $error("activate detect fell without absence");
    deact_fall_a: assert property ($fell(q.det[1].state) |->
        $past(line_mode_select_in) || (!q.det[1].present && $past(obs_end_w)))
        else $error("deactivate detect fell without absence");

    // ---------------------------------------------------------------
    // Coverage
    // ---------------------------------------------------------------
    act_on_c: cover property ($rose(act_detect_state_out));
    deact_off_c: cover property ($fell(deact_detect_state_out));
    irq_clear_c: cover property (!irq_out_n ##1 rd_clr_w ##1 irq_out_n);
    set_wins_c: cover property (rd_clr_w && chg_w != 2'b00);
    short_code_c: cover property (good_w[1] && q.det[1].gap == 4'h2);
endmodule

// ==== rtl/ibd_pkg.sv ====
package ibd_pkg;
    // ---------------------------------------------------------------
    // Register map
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_LEN_CFG = 8'h4C;
    localparam logic [7:0] ADDR_IRQ_ENST = 8'h4D;
    localparam logic [7:0] ADDR_ACT_CODE = 8'h4E;
    localparam logic [7:0] ADDR_DEACT_CODE = 8'h4F;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] CFG_WR_MASK = 8'h8F;
    // Field positions, enable/status register
    localparam int ST_ACT_PRESENT = 7;
    localparam int ST_DEACT_PRESENT = 6;
    localparam int ST_ACT_EN = 5;
    localparam int ST_DEACT_EN = 4;
    localparam int ST_ACT_EVENT = 3;
    localparam int ST_DEACT_EVENT = 2;
    localparam int ST_ACT_STATE = 1;
    localparam int ST_DEACT_STATE = 0;
    // Field positions, length register
    localparam int CFG_ACT_LO = 0;
    localparam int CFG_DEACT_LO = 2;
    // ---------------------------------------------------------------
    // Code length and timing
    // ---------------------------------------------------------------
    localparam logic [3:0] LEN_BASE = 4'h5;
    localparam logic [3:0] GAP_MAX = 4'hF;
    localparam longint OBS_INTERVAL_NS = 39800000;
    localparam longint CLK_PERIOD_NS = 4;
    localparam int OBS_CYCLES = int'(OBS_INTERVAL_NS / CLK_PERIOD_NS);
    localparam int HITS_MIN = 256;
    localparam int SUSTAIN_INTERVALS = 2;
    localparam int CODE_ACT = 0;
    localparam int CODE_DEACT = 1;
    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef struct packed {
        logic sel;
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ibd_cpu_req_t;
    typedef struct packed {
        logic [3:0] gap;
        logic [15:0] hits;
        logic present;
        logic [1:0] run;
        logic state;
        logic event_hit;
    } ibd_det_t;
    typedef struct packed {
        logic clk_s1;
        logic clk_s2;
        logic clk_s3;
        logic dat_s1;
        logic dat_s2;
        logic [7:0] hist;
        logic [23:0] tick;
        logic [7:0] len_cfg;
        logic [1:0] irq_en;
        logic [7:0] act_code;
        logic [7:0] deact_code;
        ibd_det_t [1:0] det;
        logic [7:0] rdata;
        logic irq_n;
    } ibd_state_t;
endpackage
